/* pfic_cfg_reg.v */
`timescale 1ns/1ns
`default_nettype none

module pfic_cfg_reg #(
  parameter [7:0] RESET_VAL = 8'h00,
  parameter [7:0] WRITE_MASK = 8'hFF,
  parameter LOCKABLE = 1
) (
  input wire clock, // System clock.
  input wire rst, // Power-on reset, synchronous.
  input wire sw_reset, // One-cycle software reset pulse.
  input wire lock, // Register lock level.
  input wire wr_en, // Write strobe for this register.
  input wire [7:0] wr_data, // Write data.
  output reg [7:0] value_q // Stored value.
);

  wire write_ok;

  assign write_ok = wr_en && !(lock && (LOCKABLE != 0));

  // Read-only bits keep their reset value, so a write to them has no effect.
  always @(posedge clock) begin
    if (rst || sw_reset) begin
      value_q <= RESET_VAL;
    end else if (write_ok) begin
      value_q <= (wr_data & WRITE_MASK) | (value_q & ~WRITE_MASK);
    end
  end

endmodule

`default_nettype wire

/* pfic_regs.vh */
`ifndef PFIC_REGS_VH
`define PFIC_REGS_VH

// Register byte offsets on the configuration port.
`define PFIC_ADDR_PIN_CFG_A 8'h10
`define PFIC_ADDR_PIN_CFG_D 8'h13
`define PFIC_ADDR_PRESET 8'h14
`define PFIC_ADDR_AUX_SINGLE 8'h16
`define PFIC_ADDR_ATTEN_A 8'h18
`define PFIC_ADDR_ATTEN_B 8'h19
`define PFIC_ADDR_CONTROL 8'h40
`define PFIC_ADDR_STATUS 8'h41

// Reset values.
`define PFIC_RST_PIN_CFG_A 8'h7F
`define PFIC_RST_PIN_CFG_D 8'hFC
`define PFIC_RST_PRESET 8'h01
`define PFIC_RST_AUX_SINGLE 8'h00
`define PFIC_RST_ATTEN_A 8'hFF
`define PFIC_RST_ATTEN_B 8'h37
`define PFIC_RD_UNMAPPED 8'h00

// Writable bit masks; cleared bits are read-only and hold their reset value.
`define PFIC_WMASK_PIN_CFG_A 8'hFF
`define PFIC_WMASK_PIN_CFG_D 8'hFC
`define PFIC_WMASK_PRESET 8'h1F
`define PFIC_WMASK_AUX_SINGLE 8'hFF
`define PFIC_WMASK_ATTEN_A 8'hFE
`define PFIC_WMASK_ATTEN_B 8'h3F

// Field positions.
`define PFIC_VID_EN_BIT 7
`define PFIC_PIN32_BIT 2
`define PFIC_PIN31_BIT 3
`define PFIC_PIN29_HI 5
`define PFIC_PIN29_LO 4
`define PFIC_PIN28_HI 7
`define PFIC_PIN28_LO 6
`define PFIC_PRESET_HI 4
`define PFIC_PRESET_LO 0
`define PFIC_AUX_ONE_BIT 0
`define PFIC_AUX_TWO_BIT 1
`define PFIC_SINGLE_BIT 2
`define PFIC_CHAN_HI 7
`define PFIC_CHAN_LO 3
`define PFIC_ATTA_HI 7
`define PFIC_ATTA_LO 1
`define PFIC_ATTB_P23 0
`define PFIC_ATTB_P24 1
`define PFIC_ATTB_P25 2
`define PFIC_ATTB_P28 4
`define PFIC_ATTB_P29 5
`define PFIC_CTL_LOCK_BIT 0
`define PFIC_CTL_SWRST_BIT 1

// Two-bit pin pair select codes.
`define PFIC_SEL_GPIO 2'h0
`define PFIC_SEL_SENSE15 2'h1

// Effective pin function codes.
`define PFIC_FN_GPIO 3'h0
`define PFIC_FN_FAN_DRIVE 3'h1
`define PFIC_FN_OVERTEMP 3'h2
`define PFIC_FN_SENSE15 3'h3
`define PFIC_FN_VOLTAGE_ID 3'h4

`endif

/* pfic_top.v */
// How it works
// - Pin 32 bit 2: 0 general I/O six, 1 fan drive two; voltage-ID overrides.
// - Pin 31 bit 3: 0 general I/O five, 1 fan drive one; voltage-ID overrides.
// - Pin 29 field 5:4: 00 general I/O eight, 01 1.5 V sense, 1x overtemp two.
// - Pin 28 field 7:6: 00 general I/O seven, 01 1.5 V sense, 1x overtemp one.
// - With voltage-ID inputs enabled, pin 29 is voltage-ID bit six regardless.
// - Preset register bits 0 to 4 pick five presets; bits 7:5 read-only.
// - Preset register resets to 0x01, is lockable, restored by software reset.
// - Bits 0 and 1 enable auxiliary drive on general I/O five and six.
// - Bit 2 selects single-channel conversion on channel in bits 7:3.
// - Attenuator A bits 1 to 7 drive pins 7,8,13,15,19,21,22; reset 0xFF.
// - Attenuator B bits 0,1,2,4,5 drive pins 23,24,25,28,29; reset 0x37.
// - Pin register D resets to 0xFC, lockable, bits 1:0 read-only.
// - Pin register A bit 7 enables voltage-ID inputs; resets to 0.
`timescale 1ns/1ns
`default_nettype none
`include "pfic_regs.vh"

module pfic_top (
  input wire clock, // 250 MHz system clock.
  input wire rst, // Synchronous active-high power-on reset.
  input wire [7:0] addr, // Register byte address.
  input wire [7:0] wr_data, // Register write data.
  input wire wr_stb, // One-cycle write strobe.
  input wire rd_stb, // One-cycle read strobe.
  output reg [7:0] rd_data_q, // Read data, valid the cycle after rd_stb.
  output reg [2:0] pin28_fn_q, // Effective function of pin 28.
  output reg [2:0] pin29_fn_q, // Effective function of pin 29.
  output reg [2:0] pin31_fn_q, // Effective function of pin 31.
  output reg [2:0] pin32_fn_q, // Effective function of pin 32.
  output reg voltage_id_inputs_q, // Voltage-ID inputs enabled.
  output reg sense15_active_q, // 1.5 V sensing active on pins 28 and 29.
  output reg sense15_conflict_q, // Only one of pins 28/29 asks for 1.5 V sensing.
  output reg [4:0] preset_option_q, // Preset configuration option enables.
  output reg aux_drive_enable_one_q, // Auxiliary drive on general_io_five.
  output reg aux_drive_enable_two_q, // Auxiliary drive on general_io_six.
  output reg single_channel_q, // Convert on one channel only.
  output reg [4:0] channel_select_q, // Channel for single-channel mode.
  output reg [6:0] atten_en_a_q, // Attenuators of pins 22,21,19,15,13,8,7.
  output reg [4:0] atten_en_b_q, // Attenuators of pins 29,28,25,24,23.
  output reg lock_q // Register lock, set by software, cleared by reset.
);

  wire [7:0] pin_cfg_a;
  wire [7:0] pin_cfg_d;
  wire [7:0] preset_config_select;
  wire [7:0] aux_drive_single_channel;
  wire [7:0] input_attenuator_cfg_a;
  wire [7:0] input_attenuator_cfg_b;
  reg sw_reset_q;
  reg [7:0] rd_mux;
  reg [2:0] fn28_d;
  reg [2:0] fn29_d;
  reg [2:0] fn31_d;
  reg [2:0] fn32_d;
  wire vid_en;
  wire [1:0] sel28;
  wire [1:0] sel29;
  wire want15_28;
  wire want15_29;
  wire [7:0] status_word;

  // Decodes a two-bit select field of the pins 28/29 pair.
  function [2:0] pfic_pair_fn;
    input [1:0] sel;
    begin
      case (sel)
        `PFIC_SEL_GPIO: pfic_pair_fn = `PFIC_FN_GPIO;
        `PFIC_SEL_SENSE15: pfic_pair_fn = `PFIC_FN_SENSE15;
        default: pfic_pair_fn = `PFIC_FN_OVERTEMP;
      endcase
    end
  endfunction

  // Decodes the one-bit select of pins 31 and 32.
  function [2:0] pfic_fan_fn;
    input sel;
    begin
      if (sel) begin
        pfic_fan_fn = `PFIC_FN_FAN_DRIVE;
      end else begin
        pfic_fan_fn = `PFIC_FN_GPIO;
      end
    end
  endfunction

  function wr_hit;
    input [7:0] a;
    input [7:0] target;
    input stb;
    begin
      wr_hit = stb && (a == target);
    end
  endfunction

  pfic_cfg_reg #(
    .RESET_VAL(`PFIC_RST_PIN_CFG_A),
    .WRITE_MASK(`PFIC_WMASK_PIN_CFG_A),
    .LOCKABLE(1)
  ) u_pin_cfg_a (
    .clock(clock),
    .rst(rst),
    .sw_reset(sw_reset_q),
    .lock(lock_q),
    .wr_en(wr_hit(addr, `PFIC_ADDR_PIN_CFG_A, wr_stb)),
    .wr_data(wr_data),
    .value_q(pin_cfg_a)
  );

  pfic_cfg_reg #(
    .RESET_VAL(`PFIC_RST_PIN_CFG_D),
    .WRITE_MASK(`PFIC_WMASK_PIN_CFG_D),
    .LOCKABLE(1)
  ) u_pin_cfg_d (
    .clock(clock),
    .rst(rst),
    .sw_reset(sw_reset_q),
    .lock(lock_q),
    .wr_en(wr_hit(addr, `PFIC_ADDR_PIN_CFG_D, wr_stb)),
    .wr_data(wr_data),
    .value_q(pin_cfg_d)
  );

  pfic_cfg_reg #(
    .RESET_VAL(`PFIC_RST_PRESET),
    .WRITE_MASK(`PFIC_WMASK_PRESET),
    .LOCKABLE(1)
  ) u_preset (
    .clock(clock),
    .rst(rst),
    .sw_reset(sw_reset_q),
    .lock(lock_q),
    .wr_en(wr_hit(addr, `PFIC_ADDR_PRESET, wr_stb)),
    .wr_data(wr_data),
    .value_q(preset_config_select)
  );

  pfic_cfg_reg #(
    .RESET_VAL(`PFIC_RST_AUX_SINGLE),
    .WRITE_MASK(`PFIC_WMASK_AUX_SINGLE),
    .LOCKABLE(1)
  ) u_aux_single (
    .clock(clock),
    .rst(rst),
    .sw_reset(sw_reset_q),
    .lock(lock_q),
    .wr_en(wr_hit(addr, `PFIC_ADDR_AUX_SINGLE, wr_stb)),
    .wr_data(wr_data),
    .value_q(aux_drive_single_channel)
  );

  pfic_cfg_reg #(
    .RESET_VAL(`PFIC_RST_ATTEN_A),
    .WRITE_MASK(`PFIC_WMASK_ATTEN_A),
    .LOCKABLE(1)
  ) u_atten_a (
    .clock(clock),
    .rst(rst),
    .sw_reset(sw_reset_q),
    .lock(lock_q),
    .wr_en(wr_hit(addr, `PFIC_ADDR_ATTEN_A, wr_stb)),
    .wr_data(wr_data),
    .value_q(input_attenuator_cfg_a)
  );

  pfic_cfg_reg #(
    .RESET_VAL(`PFIC_RST_ATTEN_B),
    .WRITE_MASK(`PFIC_WMASK_ATTEN_B),
    .LOCKABLE(1)
  ) u_atten_b (
    .clock(clock),
    .rst(rst),
    .sw_reset(sw_reset_q),
    .lock(lock_q),
    .wr_en(wr_hit(addr, `PFIC_ADDR_ATTEN_B, wr_stb)),
    .wr_data(wr_data),
    .value_q(input_attenuator_cfg_b)
  );

  // The lock survives a software reset, so locked settings cannot be rewritten
  // by software; the software reset itself still returns them to their reset values.
  always @(posedge clock) begin
    if (rst) begin
      lock_q <= 1'h0;
      sw_reset_q <= 1'h0;
    end else begin
      sw_reset_q <= wr_hit(addr, `PFIC_ADDR_CONTROL, wr_stb) &&
                    wr_data[`PFIC_CTL_SWRST_BIT];
      if (wr_hit(addr, `PFIC_ADDR_CONTROL, wr_stb) && wr_data[`PFIC_CTL_LOCK_BIT]) begin
        lock_q <= 1'h1;
      end
    end
  end

  assign vid_en = pin_cfg_a[`PFIC_VID_EN_BIT];
  assign sel28 = pin_cfg_d[`PFIC_PIN28_HI:`PFIC_PIN28_LO];
  assign sel29 = pin_cfg_d[`PFIC_PIN29_HI:`PFIC_PIN29_LO];
  assign want15_28 = (sel28 == `PFIC_SEL_SENSE15);
  assign want15_29 = (sel29 == `PFIC_SEL_SENSE15);

  // Voltage-ID mode takes every pin of the group, whatever its select holds.
  always @* begin
    fn28_d = pfic_pair_fn(sel28);
    fn29_d = pfic_pair_fn(sel29);
    fn31_d = pfic_fan_fn(pin_cfg_d[`PFIC_PIN31_BIT]);
    fn32_d = pfic_fan_fn(pin_cfg_d[`PFIC_PIN32_BIT]);
    // A lone 1.5 V request cannot measure, so that pin falls back to I/O.
    if (want15_28 != want15_29) begin
      if (want15_28) begin
        fn28_d = `PFIC_FN_GPIO;
      end else begin
        fn29_d = `PFIC_FN_GPIO;
      end
    end
    if (vid_en) begin
      fn28_d = `PFIC_FN_VOLTAGE_ID;
      fn29_d = `PFIC_FN_VOLTAGE_ID;
      fn31_d = `PFIC_FN_VOLTAGE_ID;
      fn32_d = `PFIC_FN_VOLTAGE_ID;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      pin28_fn_q <= `PFIC_FN_GPIO;
      pin29_fn_q <= `PFIC_FN_GPIO;
      pin31_fn_q <= `PFIC_FN_GPIO;
      pin32_fn_q <= `PFIC_FN_GPIO;
      voltage_id_inputs_q <= 1'h0;
      sense15_active_q <= 1'h0;
      sense15_conflict_q <= 1'h0;
      preset_option_q <= 5'h00;
      aux_drive_enable_one_q <= 1'h0;
      aux_drive_enable_two_q <= 1'h0;
      single_channel_q <= 1'h0;
      channel_select_q <= 5'h00;
      atten_en_a_q <= 7'h00;
      atten_en_b_q <= 5'h00;
    end else begin
      pin28_fn_q <= fn28_d;
      pin29_fn_q <= fn29_d;
      pin31_fn_q <= fn31_d;
      pin32_fn_q <= fn32_d;
      voltage_id_inputs_q <= vid_en;
      sense15_active_q <= want15_28 && want15_29 && !vid_en;
      sense15_conflict_q <= (want15_28 != want15_29) && !vid_en;
      preset_option_q <=
        preset_config_select[`PFIC_PRESET_HI:`PFIC_PRESET_LO];
      // Auxiliary drive only reaches a pin that currently serves as general I/O.
      aux_drive_enable_one_q <= aux_drive_single_channel[`PFIC_AUX_ONE_BIT] &&
                                (fn31_d == `PFIC_FN_GPIO);
      aux_drive_enable_two_q <= aux_drive_single_channel[`PFIC_AUX_TWO_BIT] &&
                                (fn32_d == `PFIC_FN_GPIO);
      single_channel_q <= aux_drive_single_channel[`PFIC_SINGLE_BIT];
      channel_select_q <=
        aux_drive_single_channel[`PFIC_CHAN_HI:`PFIC_CHAN_LO];
      atten_en_a_q <=
        input_attenuator_cfg_a[`PFIC_ATTA_HI:`PFIC_ATTA_LO];
      atten_en_b_q <= {input_attenuator_cfg_b[`PFIC_ATTB_P29],
                       input_attenuator_cfg_b[`PFIC_ATTB_P28],
                       input_attenuator_cfg_b[`PFIC_ATTB_P25],
                       input_attenuator_cfg_b[`PFIC_ATTB_P24],
                       input_attenuator_cfg_b[`PFIC_ATTB_P23]};
    end
  end

  assign status_word = {4'h0, sense15_conflict_q, sense15_active_q,
                        voltage_id_inputs_q, lock_q};

  always @* begin
    case (addr)
      `PFIC_ADDR_PIN_CFG_A: rd_mux = pin_cfg_a;
      `PFIC_ADDR_PIN_CFG_D: rd_mux = pin_cfg_d;
      `PFIC_ADDR_PRESET: rd_mux = preset_config_select;
      `PFIC_ADDR_AUX_SINGLE: rd_mux = aux_drive_single_channel;
      `PFIC_ADDR_ATTEN_A: rd_mux = input_attenuator_cfg_a;
      `PFIC_ADDR_ATTEN_B: rd_mux = input_attenuator_cfg_b;
      `PFIC_ADDR_CONTROL: rd_mux = {7'h00, lock_q};
      `PFIC_ADDR_STATUS: rd_mux = status_word;
      default: rd_mux = `PFIC_RD_UNMAPPED;
    endcase
  end

  // Read data are held between reads so a slow sampler still sees them.
  always @(posedge clock) begin
    if (rst) begin
      rd_data_q <= `PFIC_RD_UNMAPPED;
    end else if (rd_stb) begin
      rd_data_q <= rd_mux;
    end
  end

endmodule

`default_nettype wire

/* pfic_top_properties.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pfic_regs.vh"

module pfic_chk (
  input wire logic clock, // Clock.
  input wire logic rst, // Reset.
  input wire logic [7:0] addr, // Address.
  input wire logic [7:0] wr_data, // Write data.
  input wire logic wr_stb, // Write strobe.
  input wire logic rd_stb, // Read strobe.
  input wire logic [7:0] rd_data_q, // Read data.
  input wire logic [2:0] pin28_fn_q, // Pin 28 function.
  input wire logic [2:0] pin29_fn_q, // Pin 29 function.
  input wire logic [2:0] pin31_fn_q, // Pin 31 function.
  input wire logic [2:0] pin32_fn_q, // Pin 32 function.
  input wire logic voltage_id_inputs_q, // Voltage-ID enable.
  input wire logic sense15_active_q, // Sensing active.
  input wire logic aux_drive_enable_one_q, // Aux drive one.
  input wire logic [4:0] preset_option_q, // Presets.
  input wire logic single_channel_q, // Single channel.
  input wire logic [4:0] channel_select_q, // Channel.
  input wire logic [6:0] atten_en_a_q, // Attenuators A.
  input wire logic [4:0] atten_en_b_q, // Attenuators B.
  input wire logic lock_q // Lock.
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_reset_decode: assert property ($fell(rst) |=> pin28_fn_q == 3'h2 && pin29_fn_q == 3'h2
    && pin31_fn_q == 3'h1 && pin32_fn_q == 3'h1 && preset_option_q == 5'h01
    && atten_en_a_q == 7'h7F && atten_en_b_q == 5'h1F) else $error("reset decode wrong");
  a_vid_override: assert property (voltage_id_inputs_q |-> pin28_fn_q == 3'h4 &&
    pin29_fn_q == 3'h4 && pin31_fn_q == 3'h4 && pin32_fn_q == 3'h4) else $error("vid");
  a_preset_reserved: assert property (rd_stb && addr == 8'h14 |=> rd_data_q[7:5] == 3'h0)
    else $error("preset reserved bits");
  a_pind_reserved: assert property (rd_stb && addr == 8'h13 |=> rd_data_q[1:0] == 2'h0)
    else $error("pin reg reserved bits");
  a_sense_pair: assert property (sense15_active_q |-> pin28_fn_q == 3'h3 &&
    pin29_fn_q == 3'h3) else $error("sense pair");
  a_aux_gated: assert property (aux_drive_enable_one_q |-> pin31_fn_q == 3'h0)
    else $error("aux gating");
  a_preset_locked: assert property (lock_q && wr_stb && addr == 8'h14 |=> ##1
    $stable(preset_option_q)) else $error("locked write took");
  a_chan_write: assert property (!lock_q && wr_stb && addr == 8'h16 |-> ##2
    single_channel_q == $past(wr_data[2], 2) && channel_select_q == $past(wr_data[7:3], 2))
    else $error("single channel");
  a_atten_write: assert property (!lock_q && wr_stb && addr == 8'h18 |-> ##2
    atten_en_a_q == $past(wr_data[7:1], 2)) else $error("attenuator a");
endmodule

bind pfic_top pfic_chk i_pfic_chk (.clock, .rst, .addr, .wr_data, .wr_stb, .rd_stb,
  .rd_data_q, .pin28_fn_q, .pin29_fn_q, .pin31_fn_q, .pin32_fn_q, .voltage_id_inputs_q,
  .sense15_active_q, .aux_drive_enable_one_q, .preset_option_q, .single_channel_q,
  .channel_select_q, .atten_en_a_q, .atten_en_b_q, .lock_q);

`default_nettype wire

/* pfic_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module pfic_top_tb;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_stb = 1'h0;
  logic rd_stb = 1'h0;
  logic [7:0] rd_data_q;
  logic [2:0] pin28_fn_q, pin29_fn_q, pin31_fn_q, pin32_fn_q;
  logic voltage_id_inputs_q, sense15_active_q, sense15_conflict_q;
  logic [4:0] preset_option_q, channel_select_q, atten_en_b_q;
  logic aux_drive_enable_one_q, aux_drive_enable_two_q, single_channel_q, lock_q;
  logic [6:0] atten_en_a_q;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] rst_addr [7] = '{8'h10, 8'h13, 8'h14, 8'h16, 8'h18, 8'h19, 8'h55};
  logic [7:0] rst_val [7] = '{8'h7F, 8'hFC, 8'h01, 8'h00, 8'hFF, 8'h37, 8'h00};
  logic [1:0] c;

  pfic_top i_pfic_top (.clock, .rst, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data_q,
    .pin28_fn_q, .pin29_fn_q, .pin31_fn_q, .pin32_fn_q, .voltage_id_inputs_q,
    .sense15_active_q, .sense15_conflict_q, .preset_option_q, .aux_drive_enable_one_q,
    .aux_drive_enable_two_q, .single_channel_q, .channel_select_q, .atten_en_a_q,
    .atten_en_b_q, .lock_q);

  initial begin
    forever #2 clock = ~clock;
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // A run of this length needs about 155 cycles; far past that something hangs.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      $display("BAD %0t got %h expected %h", $time, got, exp);
      miscompares = miscompares + 1;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_stb <= 1'h1;
    addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_stb <= 1'h0;
    // Derived outputs follow the register one edge later.
    @(posedge clock);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    rd_stb <= 1'h1;
    addr <= a;
    @(posedge clock);
    rd_stb <= 1'h0;
    #1;
    chk(rd_data_q, exp);
  endtask

  task automatic reset_values();
    for (int i = 0; i < 7; i++) begin
      rd(rst_addr[i], rst_val[i]);
    end
    chk({pin28_fn_q, pin29_fn_q, 2'h0}, 8'h48);
    chk({pin31_fn_q, pin32_fn_q, voltage_id_inputs_q, lock_q}, 8'h24);
    chk({1'h0, atten_en_a_q}, 8'h7F);
    chk({3'h0, atten_en_b_q}, 8'h1F);
    $display("Reset values test done");
  endtask

  task automatic do_reset();
    @(posedge clock);
    rst <= 1'h1;
    repeat (5) @(posedge clock);
    rst <= 1'h0;
    repeat (2) @(posedge clock);
  endtask

  initial begin
    do_reset();
    reset_values();
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(8'h13, {c, c, c[0], c[0], 2'h3});
      rd(8'h13, {c, c, c[0], c[0], 2'h0});
      chk({5'h0, pin31_fn_q}, {7'h0, c[0]});
      chk({5'h0, pin32_fn_q}, {7'h0, c[0]});
      chk({5'h0, pin28_fn_q}, c == 2'h0 ? 8'h00 : c == 2'h1 ? 8'h03 : 8'h02);
      chk({5'h0, pin29_fn_q}, c == 2'h0 ? 8'h00 : c == 2'h1 ? 8'h03 : 8'h02);
      chk({7'h0, sense15_active_q}, {7'h0, c == 2'h1});
      wr(8'h16, 8'h03);
      chk({6'h0, aux_drive_enable_two_q, aux_drive_enable_one_q}, c[0] ? 8'h0 : 8'h3);
    end
    wr(8'h13, 8'h9C);
    chk({pin28_fn_q, pin29_fn_q, sense15_conflict_q, 1'h0}, 8'h42);
    rd(8'h41, 8'h08);
    wr(8'h10, 8'hFF);
    chk({pin28_fn_q, pin29_fn_q, 2'h0}, 8'h90);
    chk({pin31_fn_q, pin32_fn_q, voltage_id_inputs_q, 1'h0}, 8'h92);
    rd(8'h41, 8'h02);
    wr(8'h10, 8'h7F);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    $display("Pin function test done");
    wr(8'h16, 8'hAC);
    rd(8'h16, 8'hAC);
    chk({channel_select_q, single_channel_q, 2'h0}, 8'hAC);
    wr(8'h18, 8'h00);
    rd(8'h18, 8'h01);
    chk({1'h0, atten_en_a_q}, 8'h00);
    wr(8'h19, 8'hC8);
    rd(8'h19, 8'h08);
    wr(8'h19, 8'h35);
    chk({3'h0, atten_en_b_q}, 8'h1D);
    wr(8'h14, 8'hFF);
    rd(8'h14, 8'h1F);
    chk({3'h0, preset_option_q}, 8'h1F);
    $display("Field test done");
    wr(8'h40, 8'h02);
    reset_values();
    wr(8'h40, 8'h01);
    rd(8'h40, 8'h01);
    wr(8'h14, 8'h04);
    rd(8'h14, 8'h01);
    wr(8'h13, 8'h00);
    rd(8'h13, 8'hFC);
    // A software reset must leave the lock in place.
    wr(8'h40, 8'h02);
    rd(8'h41, 8'h01);
    chk({7'h0, lock_q}, 8'h01);
    $display("Lock test done");
    do_reset();
    reset_values();
    finish_test();
  end
endmodule

`default_nettype wire
